// ==== core/mmi_pkg.sv ====
package mmi_pkg;
   // Register byte addresses
   localparam logic [31:0] ADR_CTRL = 32'h1540_0000;
   localparam logic [31:0] ADR_STAT = 32'h1540_0004;
   localparam logic [31:0] ADR_OWN = 32'h1540_0008;
   localparam logic [31:0] ADR_DATA = 32'h1540_000c;
   // bus_control field positions
   localparam int CB_ACK = 7;
   localparam int CB_SRC = 6;
   localparam int CB_IE = 5;
   localparam int CB_PEND = 4;
   localparam int CB_PRE = 0;
   // bus_control_status field positions
   localparam int ST_MODE = 6;
   localparam int ST_BUSY = 5;
   localparam int ST_OE = 4;
   localparam int ST_ARB = 3;
   localparam int ST_AAS = 2;
   localparam int ST_AZ = 1;
   localparam int ST_LRB = 0;
   localparam logic [7:0] STAT_RST = 8'h00;
   // Operating modes
   localparam logic [1:0] MODE_SRX = 2'h0;
   localparam logic [1:0] MODE_STX = 2'h1;
   localparam logic [1:0] MODE_MRX = 2'h2;
   localparam logic [1:0] MODE_MTX = 2'h3;
   // Prescaler source divides; two clock phases make one bit period
   localparam int SRC_DIV_LO = 16;
   localparam int SRC_DIV_HI = 512;
   localparam logic [8:0] SRC_HALF_LO = 9'(SRC_DIV_LO / 2 - 1);
   localparam logic [8:0] SRC_HALF_HI = 9'(SRC_DIV_HI / 2 - 1);
   // Bit counter marks: ack slot and end of byte
   localparam logic [3:0] BIT_ACK = 4'h8;
   localparam logic [3:0] BIT_END = 4'h9;

   typedef enum logic [1:0] {E_IDLE, E_START, E_XFER, E_STOP} mmi_eng_t;

   typedef struct packed {
      logic ack_en;
      logic src_sel;
      logic ie;
      logic pend;
      logic [3:0] presc;
      logic [1:0] mode;
      logic busy;
      logic oe;
      logic arb;
      logic aas;
      logic az;
      logic lrb;
      logic [7:0] own;
      logic [7:0] shreg;
      logic [8:0] src_cnt;
      logic [3:0] ph_cnt;
      mmi_eng_t eng;
      logic sda_prev;
      logic scl_prev;
      logic [3:0] bit_cnt;
      logic first;
      logic active;
      logic sda_drv;
      logic scl_drv;
      logic ack;
      logic [7:0] dat;
      logic irq;
   } mmi_state_t;
endpackage

// ==== core/mmi_regs.sv ====
// Local design decision: register access over Wishbone.
`timescale 1ns/10ps
// Overview of operation
// (RL1) With ack enabled, receiver pulls data low in ack slot; transmitter releases.
// (RL2) Source select bit picks clock divided by 16 (0) or 512 (1).
// (RL3) Interrupt enable bit gates the pending flag onto the interrupt output.
// (RL4) Pending flag holds clock low; writing 0 clears and resumes, 1 ignored.
// (RL5) Pending sets on byte done, address match or general call, arbitration loss.
// (RL6) Bit clock is prescaler input divided by prescaler field plus one.
// (RL7) Software avoids prescaler 0 or 1 with divide-by-16 source.
// (RL8) Software loads next byte before clearing the pending flag.
// (RL9) Software keeps interrupt enable set even when unused.
// (RL10) Mode field: 00 slave rx, 01 slave tx, 10 master rx, 11 master tx.
// (RL11) Busy bit tracks bus start/stop; writing 1 starts, writing 0 stops.
// (RL12) After start, shift out the loaded byte; start check delay inserted.
// (RL13) Serial output enable bit enables (1) or disables (0) all activity.
// (RL14) Arbitration flag set on lost arbitration, 0 when it succeeded.
// (RL15) Address-match flag set on own address, cleared on start or stop.
// (RL16) Address-zero flag set on general call, cleared on start or stop.
// (RL17) Last-bit flag holds last sampled ack bit: 0 ack, 1 no ack.
// (RL18) Own address writable only with output disabled, readable always.
// (RL19) Own address in bits 7..1, compared only in slave modes.
// (RL20) Software may drop ack before last master receive byte.
// (RL21) Byte is eight clocks plus ack on ninth, clocked by master.
// (RL22) Clock held low after each byte until software services it.
// (RL23) First byte after start is 7-bit address plus direction bit.
// (RL24) On arbitration loss release both lines and continue as slave receiver.
module mmi_regs (
   input wire logic CLK_IN,
   input wire logic SRST_IN,
   input wire logic WB_CYC_IN,
   input wire logic WB_STB_IN,
   input wire logic WB_WE_IN,
   input wire logic [31:0] WB_ADR_IN,
   input wire logic [3:0] WB_SEL_IN,
   input wire logic [31:0] WB_DAT_IN,
   output logic [31:0] WB_DAT_OUT,
   output logic WB_ACK_OUT,
   input wire logic SDA_IN,
   output logic SDA_OUT,
   output logic SDA_OE_OUT,
   input wire logic SCL_IN,
   output logic SCL_OUT,
   output logic SCL_OE_OUT,
   output logic IRQ_OUT
);
   mmi_pkg::mmi_state_t st_reg;
   mmi_pkg::mmi_state_t st_next;
   logic req;
   logic wr;
   logic start_det;
   logic stop_det;
   logic scl_rise;
   logic scl_fall;
   logic tx;
   logic xfer;
   logic run;
   logic src_tick;
   logic ph_tick;
   logic [8:0] src_half;

   // Bus request decode; ack goes out one cycle after the request
   assign req = WB_CYC_IN && WB_STB_IN && !st_reg.ack;
   assign wr = req && WB_WE_IN && WB_SEL_IN[0];

   // Line conditions seen against the previous sample
   assign start_det = st_reg.scl_prev && SCL_IN && st_reg.sda_prev && !SDA_IN;
   assign stop_det = st_reg.scl_prev && SCL_IN && !st_reg.sda_prev && SDA_IN;
   assign scl_rise = !st_reg.scl_prev && SCL_IN;
   assign scl_fall = st_reg.scl_prev && !SCL_IN;

   // Address byte is sent by the master, later bytes follow the mode
   assign tx = st_reg.first ? st_reg.mode[1] : st_reg.mode[0]; // [RL10] [RL23]
   assign xfer = st_reg.eng != mmi_pkg::E_STOP;

   // Clock dividers run only while this end drives the clock
   assign run = st_reg.eng != mmi_pkg::E_IDLE;
   assign src_half = st_reg.src_sel ? mmi_pkg::SRC_HALF_HI : mmi_pkg::SRC_HALF_LO; // [RL2]
   assign src_tick = run && st_reg.src_cnt == src_half;
   assign ph_tick = src_tick && st_reg.ph_cnt == st_reg.presc; // [RL6]

   // Next-state logic for the whole controller
   always_comb begin
      st_next = st_reg;
      st_next.ack = req;
      st_next.sda_prev = SDA_IN;
      st_next.scl_prev = SCL_IN;
      st_next.irq = st_reg.pend && st_reg.ie; // [RL3]

      // Prescaler input divider then the bit-phase divider
      if (!run) begin
         st_next.src_cnt = 9'h000;
         st_next.ph_cnt = 4'h0;
      end else if (src_tick) begin
         st_next.src_cnt = 9'h000;
         st_next.ph_cnt = ph_tick ? 4'h0 : st_reg.ph_cnt + 4'h1; // [RL6]
      end else begin
         st_next.src_cnt = st_reg.src_cnt + 9'h001;
      end

      // Register reads are captured with the request
      if (req) begin
         case (WB_ADR_IN)
            mmi_pkg::ADR_CTRL: begin
               st_next.dat = {st_reg.ack_en, st_reg.src_sel, st_reg.ie, st_reg.pend,
                  st_reg.presc};
            end
            mmi_pkg::ADR_STAT: begin
               st_next.dat = {st_reg.mode, st_reg.busy, st_reg.oe, st_reg.arb, st_reg.aas,
                  st_reg.az, st_reg.lrb};
            end
            mmi_pkg::ADR_OWN: begin
               st_next.dat = {st_reg.own[7:1], 1'b0}; // [RL18] [RL19]
            end
            mmi_pkg::ADR_DATA: begin
               st_next.dat = st_reg.shreg;
            end
            default: begin
               st_next.dat = 8'h00;
            end
         endcase
      end

      // Register writes come first so that line events below win over them
      if (wr) begin
         case (WB_ADR_IN)
            mmi_pkg::ADR_CTRL: begin
               st_next.ack_en = WB_DAT_IN[mmi_pkg::CB_ACK];
               st_next.src_sel = WB_DAT_IN[mmi_pkg::CB_SRC];
               st_next.ie = WB_DAT_IN[mmi_pkg::CB_IE];
               st_next.presc = WB_DAT_IN[mmi_pkg::CB_PRE +: 4];
               // Writing 0 resumes; the next bit is set up while the clock is low
               if (!WB_DAT_IN[mmi_pkg::CB_PEND] && st_reg.pend) begin // [RL4]
                  st_next.pend = 1'b0;
                  st_next.sda_drv = st_reg.active && tx && !st_reg.shreg[7];
                  if (!st_reg.mode[1]) begin
                     st_next.scl_drv = 1'b0; // [RL22]
                  end
               end
            end
            mmi_pkg::ADR_STAT: begin
               st_next.mode = WB_DAT_IN[mmi_pkg::ST_MODE +: 2]; // [RL10]
               st_next.oe = WB_DAT_IN[mmi_pkg::ST_OE];
               if (WB_DAT_IN[mmi_pkg::ST_BUSY]) begin
                  // Start only from an idle bus as a master
                  if (WB_DAT_IN[mmi_pkg::ST_MODE + 1] && WB_DAT_IN[mmi_pkg::ST_OE] &&
                     !st_reg.busy && st_reg.eng == mmi_pkg::E_IDLE) begin // [RL11]
                     st_next.eng = mmi_pkg::E_START;
                     st_next.arb = 1'b0;
                  end
               end else if (st_reg.mode[1] && st_reg.eng == mmi_pkg::E_XFER) begin
                  st_next.eng = mmi_pkg::E_STOP; // [RL11]
                  st_next.pend = 1'b0;
               end
            end
            mmi_pkg::ADR_OWN: begin
               if (!st_reg.oe) begin
                  st_next.own = WB_DAT_IN[7:0]; // [RL18]
               end
            end
            mmi_pkg::ADR_DATA: begin
               if (st_reg.oe) begin
                  st_next.shreg = WB_DAT_IN[7:0];
               end
            end
            default: begin
            end
         endcase
      end

      // Start and stop seen on the lines, whoever made them
      if (start_det) begin
         st_next.busy = 1'b1; // [RL11]
         st_next.aas = 1'b0; // [RL15]
         st_next.az = 1'b0; // [RL16]
         st_next.bit_cnt = 4'h0;
         st_next.first = 1'b1; // [RL23]
         st_next.active = st_reg.eng == mmi_pkg::E_START;
      end
      if (stop_det) begin
         st_next.busy = 1'b0; // [RL11]
         st_next.aas = 1'b0; // [RL15]
         st_next.az = 1'b0; // [RL16]
         st_next.active = 1'b0;
         st_next.eng = mmi_pkg::E_IDLE;
         st_next.sda_drv = 1'b0;
         st_next.scl_drv = 1'b0;
      end

      // Rising clock: sample data, check arbitration, catch the ack bit
      if (scl_rise && st_reg.busy && xfer && st_reg.bit_cnt != mmi_pkg::BIT_END) begin
         st_next.bit_cnt = st_reg.bit_cnt + 4'h1; // [RL21]
         if (st_reg.bit_cnt == mmi_pkg::BIT_ACK) begin
            st_next.lrb = SDA_IN; // [RL17]
         end else begin
            st_next.shreg = {st_reg.shreg[6:0], SDA_IN};
            // Lost when our released line reads low; address and data bits compete, the ack bit does not
            if (st_reg.active && st_reg.mode[1] && tx && !st_reg.sda_drv && !SDA_IN) begin
               st_next.arb = 1'b1; // [RL14]
               st_next.mode = mmi_pkg::MODE_SRX; // [RL24]
               st_next.eng = mmi_pkg::E_IDLE;
               st_next.active = 1'b0;
               st_next.sda_drv = 1'b0;
               st_next.scl_drv = 1'b0;
               st_next.pend = 1'b1; // [RL5]
            end
         end
      end

      // Falling clock: set up the next bit, the ack, or end the byte
      if (scl_fall && st_reg.busy && xfer) begin
         if (st_reg.bit_cnt == mmi_pkg::BIT_END) begin
            st_next.bit_cnt = 4'h0;
            st_next.first = 1'b0;
            st_next.sda_drv = 1'b0;
            if (st_reg.active) begin
               st_next.pend = 1'b1; // [RL5]
               st_next.scl_drv = 1'b1; // [RL22]
            end
         end else if (st_reg.bit_cnt == mmi_pkg::BIT_ACK) begin
            // Address is compared once the eighth bit is in, in slave modes only
            if (st_reg.first && !st_reg.mode[1]) begin
               if (st_reg.shreg[7:1] == st_reg.own[7:1]) begin // [RL19]
                  st_next.aas = 1'b1; // [RL15]
                  st_next.active = 1'b1;
               end
               if (st_reg.shreg == 8'h00) begin
                  st_next.az = 1'b1; // [RL16]
                  st_next.active = 1'b1;
               end
            end
            st_next.sda_drv = st_next.active && !tx && st_reg.ack_en; // [RL1] [RL20]
         end else begin
            st_next.sda_drv = st_reg.active && tx && !st_reg.shreg[7]; // [RL12]
         end
      end

      // Master line sequencer, paced by the bit-phase tick
      case (st_reg.eng)
         mmi_pkg::E_START: begin
            if (ph_tick) begin
               if (!st_reg.sda_drv) begin
                  st_next.sda_drv = 1'b1;
               end else begin
                  // One full phase of data low with clock high checks the start
                  st_next.scl_drv = 1'b1; // [RL12]
                  st_next.eng = mmi_pkg::E_XFER;
               end
            end
         end
         mmi_pkg::E_XFER: begin
            // Clock stalls while pending; a slow slave stretches the low phase
            if (ph_tick && !st_reg.pend) begin // [RL4]
               if (st_reg.scl_drv) begin
                  st_next.scl_drv = 1'b0;
               end else if (SCL_IN) begin
                  st_next.scl_drv = 1'b1; // [RL21]
               end
            end
         end
         mmi_pkg::E_STOP: begin
            if (ph_tick) begin
               if (!st_reg.sda_drv) begin
                  if (st_reg.scl_drv) begin
                     st_next.sda_drv = 1'b1;
                  end else begin
                     st_next.scl_drv = 1'b1;
                  end
               end else if (st_reg.scl_drv) begin
                  st_next.scl_drv = 1'b0;
               end else if (SCL_IN) begin
                  st_next.sda_drv = 1'b0; // [RL11]
               end
            end
         end
         default: begin
         end
      endcase

      // Disabled output means no driving and no transfer at all
      if (!st_next.oe) begin // [RL13]
         st_next.sda_drv = 1'b0;
         st_next.scl_drv = 1'b0;
         st_next.eng = mmi_pkg::E_IDLE;
         st_next.active = 1'b0;
      end
   end

   // State register with synchronous reset
   always_ff @(posedge CLK_IN) begin
      if (SRST_IN) begin
         // Line samples start at the released level so no false edge follows reset
         st_reg <= '0;
         st_reg.sda_prev <= 1'b1;
         st_reg.scl_prev <= 1'b1;
      end else begin
         st_reg <= st_next;
      end
   end

   // Open-drain pins only ever pull low
   assign SDA_OUT = 1'b0;
   assign SCL_OUT = 1'b0;
   assign SDA_OE_OUT = st_reg.sda_drv;
   assign SCL_OE_OUT = st_reg.scl_drv;
   assign IRQ_OUT = st_reg.irq;
   assign WB_ACK_OUT = st_reg.ack;
   assign WB_DAT_OUT = {24'h000000, st_reg.dat};

   default clocking cb @(posedge CLK_IN); endclocking
   default disable iff (SRST_IN);

   // Receiver with ack enabled pulls the line in the ack slot
   property p_ack_slot;
      (scl_fall && st_reg.busy && xfer && st_reg.bit_cnt == mmi_pkg::BIT_ACK && st_next.active
         && !tx && st_reg.ack_en && st_next.oe) |=> SDA_OE_OUT;
   endproperty
   a_ack_slot: assert property (p_ack_slot) else $error("ack not driven"); // [RL1]

   // Small source divide gives eight cycles per source tick
   property p_src_div;
      (run && !st_reg.src_sel && st_reg.src_cnt == 9'h000) |-> ##7 (src_tick || !run);
   endproperty
   a_src_div: assert property (p_src_div) else $error("source divide wrong"); // [RL2]

   // Interrupt follows pending only while enabled
   property p_irq;
      (st_reg.pend && st_reg.ie) [*2] |-> IRQ_OUT;
   endproperty
   a_irq: assert property (p_irq) else $error("interrupt not raised"); // [RL3]

   // Active slave holds the clock low while pending
   property p_hold;
      (st_reg.pend && st_reg.active && !st_reg.mode[1] && !wr && !stop_det && st_reg.oe)
         [*2] |-> SCL_OE_OUT;
   endproperty
   a_hold: assert property (p_hold) else $error("clock not held"); // [RL4]

   // Busy tracks start and stop on the lines
   property p_busy;
      (start_det |=> st_reg.busy) and (stop_det |=> !st_reg.busy);
   endproperty
   a_busy: assert property (p_busy) else $error("busy wrong"); // [RL11]

   // Lost arbitration leaves a released slave receiver with pending set
   property p_arb;
      $rose(st_reg.arb) |-> (st_reg.mode == mmi_pkg::MODE_SRX && !SDA_OE_OUT && st_reg.pend);
   endproperty
   a_arb: assert property (p_arb) else $error("arbitration loss wrong"); // [RL14]

   // Address flags clear on start or stop
   property p_flags;
      (start_det || stop_det) |=> (!st_reg.aas && !st_reg.az);
   endproperty
   a_flags: assert property (p_flags) else $error("address flags kept"); // [RL15]

   // Own address is locked while output is enabled
   property p_own;
      (wr && WB_ADR_IN == mmi_pkg::ADR_OWN && st_reg.oe) |=> $stable(st_reg.own);
   endproperty
   a_own: assert property (p_own) else $error("own address written"); // [RL18]

   // Ack slot sample lands in the last-bit flag
   property p_lrb;
      (scl_rise && st_reg.busy && xfer && st_reg.bit_cnt == mmi_pkg::BIT_ACK)
         |=> st_reg.lrb == $past(SDA_IN);
   endproperty
   a_lrb: assert property (p_lrb) else $error("last bit wrong"); // [RL17]
endmodule // mmi_regs

// ==== tb/mmi_slave_model.sv ====
`timescale 1ns/10ps
// Write-only slave on the two-wire bus; acks its own address and the bytes after it
module mmi_slave_model #(
   parameter logic [6:0] ADDR = 7'h52
) (
   input wire logic clk_in,
   input wire logic sda_in,
   input wire logic scl_in,
   input wire logic nack_in,
   output logic sda_oe_out
);
   logic sda_q = 1'b1;
   logic scl_q = 1'b1;
   logic first = 1'b0;
   logic hit = 1'b0;
   logic [3:0] cnt = 4'h0;
   logic [7:0] sh = 8'h00;
   initial sda_oe_out = 1'b0;
   // Lines are sampled every clock; only edges of the wire matter
   always @(posedge clk_in) begin
      sda_q <= sda_in;
      scl_q <= scl_in;
      if (scl_in && scl_q && sda_q && !sda_in) begin
         cnt <= 4'h0;
         first <= 1'b1;
         hit <= 1'b0;
      end else if (scl_in && !scl_q) begin
         cnt <= cnt + 4'h1;
         sh <= {sh[6:0], sda_in};
      end else if (!scl_in && scl_q && cnt == 4'h8) begin
         // Ack only a write to our address; data changes only while clock is low
         if (first) begin
            hit <= (sh[7:1] == ADDR) && !sh[0];
            sda_oe_out <= (sh[7:1] == ADDR) && !sh[0] && !nack_in;
         end else begin
            sda_oe_out <= hit && !nack_in;
         end
         first <= 1'b0;
      end else if (!scl_in && scl_q && cnt == 4'h9) begin
         sda_oe_out <= 1'b0;
         cnt <= 4'h0;
      end
   end
endmodule // mmi_slave_model

// ==== tb/test_multimaster_i2c_regs.sv ====
`timescale 1ns/10ps
`define CHK(got, exp) begin n_compared++; if ((got) !== (exp)) begin n_mismatch++; \
   $display("wrong value at %0t: got %h expected %h", $time, (got), (exp)); end end
module test_multimaster_i2c_regs;
   logic clk = 1'b0;
   logic srst = 1'b1;
   logic cyc = 1'b0;
   logic stb = 1'b0;
   logic we = 1'b0;
   logic [31:0] adr = 32'h0;
   logic [31:0] wdat = 32'h0;
   logic [31:0] rdat;
   logic ack, sda_oe, scl_oe, irq, m_sda;
   logic nack = 1'b0;
   logic tb_sda = 1'b0;
   logic tb_scl = 1'b0;
   int n_mismatch = 0;
   int n_compared = 0;
   int cycles = 0;
   // Open-drain wires with pull-ups: low if anyone pulls
   wire sda_w = !(sda_oe | m_sda | tb_sda);
   wire scl_w = !(scl_oe | tb_scl);

   always #25 clk = !clk;

   mmi_regs dut (.CLK_IN(clk), .SRST_IN(srst), .WB_CYC_IN(cyc), .WB_STB_IN(stb),
      .WB_WE_IN(we), .WB_ADR_IN(adr), .WB_SEL_IN(4'h1), .WB_DAT_IN(wdat),
      .WB_DAT_OUT(rdat), .WB_ACK_OUT(ack), .SDA_IN(sda_w), .SDA_OUT(), .SDA_OE_OUT(sda_oe),
      .SCL_IN(scl_w), .SCL_OUT(), .SCL_OE_OUT(scl_oe), .IRQ_OUT(irq));
   mmi_slave_model peer (.clk_in(clk), .sda_in(sda_w), .scl_in(scl_w), .nack_in(nack),
      .sda_oe_out(m_sda));

   // Hang guard: a stuck wait still reaches the verdict
   always @(posedge clk) begin
      cycles++;
      if (cycles == 60000) begin
         n_mismatch++;
         end_sim();
      end
   end

   task automatic end_sim();
      $display("compared %0d mismatches %0d", n_compared, n_mismatch);
      if (n_mismatch == 0 && n_compared > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask

   // Classic single cycle: hold until ack is sampled, then release
   task automatic wb(input logic w, input logic [31:0] a, input logic [7:0] d,
         output logic [7:0] q);
      int n;
      n = 0;
      @(posedge clk);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      wdat <= {24'h0, d};
      // Only ack or the hang guard ends this wait; ack is seen one edge after the take edge
      do begin
         @(posedge clk);
         n++;
      end while (ack !== 1'b1);
      q = rdat[7:0];
      cyc <= 1'b0;
      stb <= 1'b0;
      `CHK(n, 2)
   endtask

   task automatic wr(input logic [31:0] a, input logic [7:0] d);
      logic [7:0] q;
      wb(1'b1, a, d, q);
   endtask

   task automatic rd(input logic [31:0] a, input logic [7:0] m, input logic [7:0] e);
      logic [7:0] q;
      wb(1'b0, a, 8'h00, q);
      `CHK(q & m, e)
   endtask

   task automatic wait_irq();
      int n;
      n = 0;
      while (irq !== 1'b1 && n < 8000) begin
         @(posedge clk);
         n++;
      end
      `CHK(irq, 1'b1)
   endtask

   // Collect nine bits at clock rises; period is taken between the first two
   task automatic watch(output logic [8:0] b, output int per);
      int n, i, t0;
      logic p;
      n = 0;
      i = 0;
      t0 = 0;
      per = 0;
      p = scl_w;
      while (i < 9 && n < 20000) begin
         @(posedge clk);
         n++;
         if (scl_w && !p) begin
            b = {b[7:0], sda_w};
            if (i == 1) per = n - t0;
            t0 = n;
            i++;
         end
         p = scl_w;
      end
   endtask

   task automatic byte_out(input logic [31:0] a, input logic [7:0] v, input logic [7:0] d,
         input logic nk, input int per_exp);
      logic [8:0] b;
      int per;
      nack <= nk;
      fork
         wr(a, v);
         watch(b, per);
      join
      `CHK(b, {d, nk})
      `CHK(per, per_exp)
      wait_irq();
   endtask

   task automatic stop_bus(input logic [7:0] e);
      logic [7:0] q;
      int n;
      wr(mmi_pkg::ADR_STAT, 8'hd0);
      n = 0;
      q = 8'hff;
      while (q[5] !== 1'b0 && n < 1000) begin
         wb(1'b0, mmi_pkg::ADR_STAT, 8'h00, q);
         n++;
      end
      `CHK(q, e)
      `CHK({sda_w, scl_w, irq}, 3'b110)
   endtask

   // Bench acting as another master; 40 cycles per half bit
   task automatic half();
      repeat (40) @(posedge clk);
   endtask

   task automatic tb_byte(input logic [7:0] d, output logic a);
      for (int i = 7; i >= 0; i--) begin
         tb_sda <= !d[i];
         half();
         tb_scl <= 1'b0;
         half();
         tb_scl <= 1'b1;
      end
      tb_sda <= 1'b0;
      half();
      tb_scl <= 1'b0;
      half();
      a = sda_w;
      tb_scl <= 1'b1;
      half();
   endtask

   task automatic tb_frame(input logic [7:0] d, output logic a);
      tb_sda <= 1'b1;
      half();
      tb_scl <= 1'b1;
      tb_byte(d, a);
   endtask

   task automatic tb_stop();
      tb_sda <= 1'b1;
      half();
      tb_scl <= 1'b0;
      half();
      tb_sda <= 1'b0;
      half();
   endtask

   task automatic t_regs();
      rd(mmi_pkg::ADR_CTRL, 8'hff, 8'h00);
      rd(mmi_pkg::ADR_STAT, 8'hff, mmi_pkg::STAT_RST);
      rd(32'h1540_0010, 8'hff, 8'h00);
      wr(mmi_pkg::ADR_OWN, 8'h37);
      rd(mmi_pkg::ADR_OWN, 8'hff, 8'h36);
      wr(mmi_pkg::ADR_STAT, 8'h10);
      wr(mmi_pkg::ADR_OWN, 8'h55);
      rd(mmi_pkg::ADR_OWN, 8'hff, 8'h36);
      wr(mmi_pkg::ADR_CTRL, 8'hb3);
      rd(mmi_pkg::ADR_CTRL, 8'hff, 8'ha3);
      `CHK(irq, 1'b0)
   endtask

   // Slave receive: own address then general call, flags cleared by stop
   task automatic t_slave();
      logic a;
      tb_frame(8'h36, a);
      `CHK(a, 1'b0)
      wait_irq();
      // Let go of our own clock pull so only the held line is seen
      tb_scl <= 1'b0;
      repeat (2) @(posedge clk);
      `CHK(scl_w, 1'b0)
      tb_scl <= 1'b1;
      rd(mmi_pkg::ADR_STAT, 8'hfe, 8'h34);
      wr(mmi_pkg::ADR_CTRL, 8'ha3);
      tb_stop();
      rd(mmi_pkg::ADR_STAT, 8'hfe, 8'h10);
      tb_frame(8'h00, a);
      `CHK(a, 1'b0)
      wait_irq();
      rd(mmi_pkg::ADR_STAT, 8'hfe, 8'h32);
      wr(mmi_pkg::ADR_CTRL, 8'ha3);
      tb_stop();
      rd(mmi_pkg::ADR_STAT, 8'hfe, 8'h10);
   endtask

   // Master transmit: acked address, masked pending, nacked data, slow source
   task automatic t_master();
      wr(mmi_pkg::ADR_CTRL, 8'ha2);
      wr(mmi_pkg::ADR_DATA, 8'ha4);
      byte_out(mmi_pkg::ADR_STAT, 8'hf0, 8'ha4, 1'b0, 48);
      rd(mmi_pkg::ADR_STAT, 8'hff, 8'hf0);
      rd(mmi_pkg::ADR_CTRL, 8'hff, 8'hb2);
      wr(mmi_pkg::ADR_CTRL, 8'h92);
      @(posedge clk);
      rd(mmi_pkg::ADR_CTRL, 8'hff, 8'h92);
      `CHK({irq, scl_w}, 2'b00)
      wr(mmi_pkg::ADR_DATA, 8'h5a);
      byte_out(mmi_pkg::ADR_CTRL, 8'ha2, 8'h5a, 1'b1, 48);
      rd(mmi_pkg::ADR_STAT, 8'hff, 8'hf1);
      stop_bus(8'hd1);
      wr(mmi_pkg::ADR_CTRL, 8'he0);
      wr(mmi_pkg::ADR_DATA, 8'ha4);
      byte_out(mmi_pkg::ADR_STAT, 8'hf0, 8'ha4, 1'b0, 512);
      stop_bus(8'hd0);
   endtask

   // Master receive: unacked read address, last byte with ack generation off
   task automatic t_mrx();
      wr(mmi_pkg::ADR_CTRL, 8'ha2);
      wr(mmi_pkg::ADR_DATA, 8'ha5);
      byte_out(mmi_pkg::ADR_STAT, 8'hb0, 8'ha5, 1'b1, 48);
      byte_out(mmi_pkg::ADR_CTRL, 8'h22, 8'hff, 1'b1, 48);
      rd(mmi_pkg::ADR_DATA, 8'hff, 8'hff);
      stop_bus(8'hd1);
   endtask

   // Another master pulls data low while ours sends a one: arbitration is lost
   task automatic t_arb();
      wr(mmi_pkg::ADR_DATA, 8'hff);
      wr(mmi_pkg::ADR_STAT, 8'hf0);
      while (scl_w !== 1'b0) @(posedge clk);
      tb_sda <= 1'b1;
      wait_irq();
      rd(mmi_pkg::ADR_STAT, 8'hfe, 8'h38);
      `CHK({sda_oe, scl_oe}, 2'b00)
      // Releasing data with the clock high makes the stop
      tb_sda <= 1'b0;
      wr(mmi_pkg::ADR_CTRL, 8'ha2);
      rd(mmi_pkg::ADR_STAT, 8'hfe, 8'h18);
   endtask

   // Reset for two edges, then the scenarios in turn
   initial begin
      repeat (2) @(posedge clk);
      srst <= 1'b0;
      t_regs();
      t_slave();
      t_master();
      t_mrx();
      t_arb();
      end_sim();
   end
endmodule // test_multimaster_i2c_regs
